// file: hdl/tfn_pkg.sv
// Constants and types for the telemetry, fault and nonvolatile program register block
package tfn_pkg;
  localparam int CLK_MHZ = 125;
  localparam int FAST_PERIOD_US = 32;
  localparam int PRECISE_PERIOD_US = 128;
  localparam int FAST_CYC = FAST_PERIOD_US * CLK_MHZ;
  localparam int PRECISE_CYC_DEF = PRECISE_PERIOD_US * CLK_MHZ;
  localparam int FAST_CNT_W = 12;
  localparam int PREC_CNT_W = 16;

  localparam logic [7:0] ADDR_IND_RES = 8'h02;
  localparam logic [7:0] ADDR_CUR_FAST = 8'h48;
  localparam logic [7:0] ADDR_CUR_LO = 8'h4a;
  localparam logic [7:0] ADDR_CUR_HI = 8'h4b;
  localparam logic [7:0] ADDR_HEAT_LO = 8'h4e;
  localparam logic [7:0] ADDR_HEAT_HI = 8'h4f;
  localparam logic [7:0] ADDR_FAULT = 8'h54;
  localparam logic [7:0] ADDR_PROG = 8'h60;
  localparam logic [7:0] ADDR_UNLOCK = 8'h61;

  localparam logic [7:0] UNLOCK_KEY = 8'h61;
  localparam logic [4:0] PROG_PATTERN = 5'h12;
  localparam int CMD_LSB = 3;
  localparam int NIB_LSB = 4;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [4:0] FAULT_PAD = 5'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [4:0] CMD_RESET = 5'h00;
  localparam logic [3:0] IND_RES_RESET = 4'h0;

  typedef enum logic [0:0] {
    TFN_IDLE = 1'b0,
    TFN_BURN = 1'b1
  } tfn_state_e;

  // Packing order puts each flag at its register bit
  typedef struct packed {
    logic output_short_flag;
    logic output_overcurrent_flag;
    logic die_overheat_flag;
  } tfn_fault_s;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } tfn_reg_req_s;
endpackage

// file: hdl/tfn_regs.sv
// Telemetry result, fault status and nonvolatile program register block
`timescale 1ns/10ps
module tfn_regs #(
  parameter int unsigned PRECISE_CYC = tfn_pkg::PRECISE_CYC_DEF
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire tfn_pkg::tfn_reg_req_s reg_req_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [7:0] current_fast_code_in,
  input wire logic [11:0] current_precise_code_in,
  input wire logic [11:0] die_heat_code_in,
  input wire tfn_pkg::tfn_fault_s faults_in,
  input wire logic nvm_write_done_in,
  output logic nvm_write_req_out,
  output logic [3:0] inductor_resistance_code_out
);
  localparam logic [tfn_pkg::FAST_CNT_W-1:0] FAST_LAST = tfn_pkg::FAST_CNT_W'(tfn_pkg::FAST_CYC - 1);
  localparam logic [tfn_pkg::PREC_CNT_W-1:0] PREC_LAST = tfn_pkg::PREC_CNT_W'(PRECISE_CYC - 1);

  logic [tfn_pkg::FAST_CNT_W-1:0] fast_cnt, next_fast_cnt;
  logic [tfn_pkg::PREC_CNT_W-1:0] prec_cnt, next_prec_cnt;
  logic [7:0] current_fast, next_current_fast;
  logic [11:0] pair_val [2];
  logic [11:0] next_pair_val [2];
  logic [11:0] pend_val [2];
  logic [11:0] next_pend_val [2];
  logic [1:0] pend, next_pend, rd_lo, next_rd_lo, rd_hi, next_rd_hi;
  logic [1:0] lo_hit, hi_hit, load;
  tfn_pkg::tfn_fault_s fault_q, next_fault_q;
  logic [4:0] cmd_field, next_cmd_field;
  logic [7:0] unlock_key, next_unlock_key;
  logic [3:0] ind_res, next_ind_res;
  logic done, next_done;
  logic nvm_req, next_nvm_req;
  tfn_pkg::tfn_state_e state, next_state;
  logic [7:0] rdata, next_rdata;
  logic fast_tick, prec_tick, prog_wr, start;
  logic [11:0] raw [2];
  logic [7:0] lo_addr [2];
  logic [7:0] hi_addr [2];

  assign fast_tick = (fast_cnt == FAST_LAST);
  assign prec_tick = (prec_cnt == PREC_LAST);
  assign raw[0] = current_precise_code_in;
  assign raw[1] = die_heat_code_in;
  assign lo_addr[0] = tfn_pkg::ADDR_CUR_LO;
  assign lo_addr[1] = tfn_pkg::ADDR_HEAT_LO;
  assign hi_addr[0] = tfn_pkg::ADDR_CUR_HI;
  assign hi_addr[1] = tfn_pkg::ADDR_HEAT_HI;
  assign prog_wr = reg_req_in.wr && (reg_req_in.addr == tfn_pkg::ADDR_PROG);
  // Unlock stays in force while the key is held; a busy burn refuses new starts
  assign start = prog_wr && (reg_req_in.wdata[7:tfn_pkg::CMD_LSB] == tfn_pkg::PROG_PATTERN) &&
                 (unlock_key == tfn_pkg::UNLOCK_KEY) && (state == tfn_pkg::TFN_IDLE);

  // Conversion timing and results
  always_comb begin
    next_fast_cnt = fast_tick ? '0 : fast_cnt + 1'b1;
    next_prec_cnt = prec_tick ? '0 : prec_cnt + 1'b1;
    next_current_fast = fast_tick ? current_fast_code_in : current_fast;
    next_fault_q = faults_in;
    for (int i = 0; i < 2; i++) begin
      lo_hit[i] = reg_req_in.rd && (reg_req_in.addr == lo_addr[i]);
      hi_hit[i] = reg_req_in.rd && (reg_req_in.addr == hi_addr[i]);
      // A read in the load cycle would see old data, so loading waits a cycle
      load[i] = pend[i] && rd_lo[i] && rd_hi[i] && !lo_hit[i] && !hi_hit[i];
      next_pend_val[i] = prec_tick ? raw[i] : pend_val[i];
      next_pend[i] = pend[i] || prec_tick;
      next_rd_lo[i] = rd_lo[i] || lo_hit[i];
      next_rd_hi[i] = rd_hi[i] || hi_hit[i];
      next_pair_val[i] = pair_val[i];
      if (load[i]) begin
        next_pair_val[i] = pend_val[i];
        next_pend[i] = prec_tick;
        next_rd_lo[i] = 1'b0;
        next_rd_hi[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fast_cnt <= '0;
      prec_cnt <= '0;
      current_fast <= tfn_pkg::BYTE_ZERO;
      fault_q <= '0;
      for (int i = 0; i < 2; i++) begin
        pair_val[i] <= tfn_pkg::CODE_ZERO;
        pend_val[i] <= tfn_pkg::CODE_ZERO;
      end
      pend <= 2'b00;
      // Both halves count as read so the first conversion loads at once
      rd_lo <= 2'b11;
      rd_hi <= 2'b11;
    end else begin
      fast_cnt <= next_fast_cnt;
      prec_cnt <= next_prec_cnt;
      current_fast <= next_current_fast;
      fault_q <= next_fault_q;
      for (int i = 0; i < 2; i++) begin
        pair_val[i] <= next_pair_val[i];
        pend_val[i] <= next_pend_val[i];
      end
      pend <= next_pend;
      rd_lo <= next_rd_lo;
      rd_hi <= next_rd_hi;
    end
  end

  // Control registers and program sequence
  always_comb begin
    next_cmd_field = cmd_field;
    next_unlock_key = unlock_key;
    next_ind_res = ind_res;
    next_done = done;
    next_nvm_req = nvm_req;
    next_state = state;
    if (prog_wr) begin
      next_cmd_field = reg_req_in.wdata[7:tfn_pkg::CMD_LSB];
    end
    if (reg_req_in.wr && (reg_req_in.addr == tfn_pkg::ADDR_UNLOCK)) begin
      next_unlock_key = reg_req_in.wdata;
    end
    if (reg_req_in.wr && (reg_req_in.addr == tfn_pkg::ADDR_IND_RES)) begin
      next_ind_res = reg_req_in.wdata[7:tfn_pkg::NIB_LSB];
    end
    case (state)
      tfn_pkg::TFN_IDLE: begin
        if (start) begin
          next_done = 1'b0;
          next_nvm_req = 1'b1;
          next_state = tfn_pkg::TFN_BURN;
        end
      end
      tfn_pkg::TFN_BURN: begin
        if (nvm_write_done_in) begin
          next_done = 1'b1;
          next_nvm_req = 1'b0;
          next_state = tfn_pkg::TFN_IDLE;
        end
      end
      default: begin
        next_nvm_req = 1'b0;
        next_state = tfn_pkg::TFN_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_field <= tfn_pkg::CMD_RESET;
      unlock_key <= tfn_pkg::BYTE_ZERO;
      ind_res <= tfn_pkg::IND_RES_RESET;
      done <= 1'b0;
      nvm_req <= 1'b0;
      state <= tfn_pkg::TFN_IDLE;
    end else begin
      cmd_field <= next_cmd_field;
      unlock_key <= next_unlock_key;
      ind_res <= next_ind_res;
      done <= next_done;
      nvm_req <= next_nvm_req;
      state <= next_state;
    end
  end

  // Read data, one cycle after the strobe
  always_comb begin
    next_rdata = rdata;
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        tfn_pkg::ADDR_IND_RES: next_rdata = {ind_res, tfn_pkg::NIB_ZERO};
        tfn_pkg::ADDR_CUR_FAST: next_rdata = current_fast;
        tfn_pkg::ADDR_CUR_LO: next_rdata = {pair_val[0][3:0], tfn_pkg::NIB_ZERO};
        tfn_pkg::ADDR_CUR_HI: next_rdata = pair_val[0][11:4];
        tfn_pkg::ADDR_HEAT_LO: next_rdata = {pair_val[1][3:0], tfn_pkg::NIB_ZERO};
        tfn_pkg::ADDR_HEAT_HI: next_rdata = pair_val[1][11:4];
        tfn_pkg::ADDR_FAULT: next_rdata = {tfn_pkg::FAULT_PAD, fault_q};
        tfn_pkg::ADDR_PROG: next_rdata = {cmd_field, 1'b0, done, 1'b0};
        tfn_pkg::ADDR_UNLOCK: next_rdata = unlock_key;
        default: next_rdata = tfn_pkg::BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata <= tfn_pkg::BYTE_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_out = rdata;
  assign nvm_write_req_out = nvm_req;
  assign inductor_resistance_code_out = ind_res;

  sequence s_start;
    start;
  endsequence

  sequence s_burn_end;
    (state == tfn_pkg::TFN_BURN) && nvm_write_done_in;
  endsequence

  property p_fast_load;
    @(posedge mclk_in) disable iff (rst_in)
    fast_tick |=> current_fast == $past(current_fast_code_in);
  endproperty
  a_fast_load: assert property (p_fast_load) else $error("fast result not loaded on tick");

  property p_fast_hold;
    @(posedge mclk_in) disable iff (rst_in)
    !fast_tick |=> $stable(current_fast);
  endproperty
  a_fast_hold: assert property (p_fast_hold) else $error("fast result changed between ticks");

  property p_pair_wait;
    @(posedge mclk_in) disable iff (rst_in)
    !(rd_lo[0] && rd_hi[0]) |=> $stable(pair_val[0]) [*1];
  endproperty
  a_pair_wait: assert property (p_pair_wait) else $error("current pair reloaded before both reads");

  property p_cur_lo;
    @(posedge mclk_in) disable iff (rst_in)
    (reg_req_in.rd && reg_req_in.addr == tfn_pkg::ADDR_CUR_LO) |=>
      reg_rdata_out == {pair_val[0][3:0], tfn_pkg::NIB_ZERO};
  endproperty
  a_cur_lo: assert property (p_cur_lo) else $error("current low byte layout wrong");

  property p_heat_hi;
    @(posedge mclk_in) disable iff (rst_in)
    (reg_req_in.rd && reg_req_in.addr == tfn_pkg::ADDR_HEAT_HI) |=> reg_rdata_out == pair_val[1][11:4];
  endproperty
  a_heat_hi: assert property (p_heat_hi) else $error("temperature high byte wrong");

  property p_fault_read;
    @(posedge mclk_in) disable iff (rst_in)
    (reg_req_in.rd && reg_req_in.addr == tfn_pkg::ADDR_FAULT) |=>
      reg_rdata_out == {tfn_pkg::FAULT_PAD, $past(fault_q)};
  endproperty
  a_fault_read: assert property (p_fault_read) else $error("fault register readback wrong");

  property p_start_clears;
    @(posedge mclk_in) disable iff (rst_in)
    s_start |=> !done && nvm_write_req_out;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("program start did not clear done");

  property p_burn_low;
    @(posedge mclk_in) disable iff (rst_in)
    s_start |=> !done throughout (state == tfn_pkg::TFN_BURN) [*2];
  endproperty
  a_burn_low: assert property (p_burn_low) else $error("done rose during write cycle");

  property p_done_sets;
    @(posedge mclk_in) disable iff (rst_in)
    s_burn_end |=> done && !nvm_write_req_out;
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("done not set on completion");

  property p_locked;
    @(posedge mclk_in) disable iff (rst_in)
    (prog_wr && (unlock_key != tfn_pkg::UNLOCK_KEY || reg_req_in.wdata[7:tfn_pkg::CMD_LSB] != tfn_pkg::PROG_PATTERN)
      && state == tfn_pkg::TFN_IDLE) |=> $stable(done) && !nvm_write_req_out;
  endproperty
  a_locked: assert property (p_locked) else $error("program started while locked or bad pattern");

  property p_busy_refuse;
    @(posedge mclk_in) disable iff (rst_in)
    (prog_wr && state == tfn_pkg::TFN_BURN && !nvm_write_done_in) |=> state == tfn_pkg::TFN_BURN && !done;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("program write during burn not refused");

  property p_heat_lo;
    @(posedge mclk_in) disable iff (rst_in)
    (reg_req_in.rd && reg_req_in.addr == tfn_pkg::ADDR_HEAT_LO) |=>
      reg_rdata_out == {pair_val[1][3:0], tfn_pkg::NIB_ZERO};
  endproperty
  a_heat_lo: assert property (p_heat_lo) else $error("temperature low byte layout wrong");

  property p_cur_hi;
    @(posedge mclk_in) disable iff (rst_in)
    (reg_req_in.rd && reg_req_in.addr == tfn_pkg::ADDR_CUR_HI) |=> reg_rdata_out == pair_val[0][11:4];
  endproperty
  a_cur_hi: assert property (p_cur_hi) else $error("current high byte wrong");

  property p_prog_read;
    @(posedge mclk_in) disable iff (rst_in)
    (reg_req_in.rd && reg_req_in.addr == tfn_pkg::ADDR_PROG) |=>
      reg_rdata_out == {$past(cmd_field), 1'b0, $past(done), 1'b0};
  endproperty
  a_prog_read: assert property (p_prog_read) else $error("program register readback wrong");

  // A write to its own address stores the upper data nibble as the code
  property p_ind_res;
    @(posedge mclk_in) disable iff (rst_in)
    (reg_req_in.wr && reg_req_in.addr == tfn_pkg::ADDR_IND_RES) |=>
      inductor_resistance_code_out == $past(reg_req_in.wdata[7:tfn_pkg::NIB_LSB]);
  endproperty
  a_ind_res: assert property (p_ind_res) else $error("inductor resistance code not stored");
endmodule

// file: tb/tfn_nvm_model.sv
// Behavioural nonvolatile memory answering the burn handshake
`timescale 1ns/10ps
module tfn_nvm_model #(
  parameter int DELAY = 20
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic write_req_in,
  output logic write_done_out
);
  int cnt;

  // Done pulses after a fixed delay of held request, and again after each further delay while the request stays high
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 0;
      write_done_out <= 1'b0;
    end else begin
      write_done_out <= 1'b0;
      if (write_req_in && !write_done_out) begin
        if (cnt == DELAY) begin
          write_done_out <= 1'b1;
          cnt <= 0;
        end else begin
          cnt <= cnt + 1;
        end
      end else begin
        cnt <= 0;
      end
    end
  end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the telemetry, fault and program register block
`timescale 1ns/10ps
module tb_top;
  typedef struct {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} tfn_row_s;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  tfn_pkg::tfn_reg_req_s req = '0;
  logic [7:0] rdata;
  logic [7:0] fast = 8'h5a;
  logic [11:0] prec = 12'habc;
  logic [11:0] heat = 12'h123;
  tfn_pkg::tfn_fault_s flt = '0;
  logic done;
  logic wreq;
  logic [3:0] ind;
  int errors = 0;
  int check_count = 0;
  logic [7:0] map [9] = '{8'h02, 8'h48, 8'h4a, 8'h4b, 8'h4e, 8'h4f, 8'h54, 8'h60, 8'h61};
  tfn_row_s rows [10] = '{'{8'h48, 1'b0, 8'h00, 8'h5a}, '{8'h4e, 1'b0, 8'h00, 8'h30},
    '{8'h4f, 1'b0, 8'h00, 8'h12}, '{8'h02, 1'b1, 8'ha5, 8'h00}, '{8'h02, 1'b0, 8'h00, 8'ha0},
    '{8'h54, 1'b1, 8'hff, 8'h00}, '{8'h54, 1'b0, 8'h00, 8'h00}, '{8'h55, 1'b0, 8'h00, 8'h00},
    '{8'h4b, 1'b1, 8'h11, 8'h00}, '{8'h4b, 1'b0, 8'h00, 8'h78}};

  always #4 mclk_in = ~mclk_in;

  // Short precise period keeps the pairing scenario brief
  tfn_regs #(.PRECISE_CYC(64)) tfn_regs_inst (.mclk_in(mclk_in), .rst_in(rst_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .current_fast_code_in(fast), .current_precise_code_in(prec),
    .die_heat_code_in(heat), .faults_in(flt), .nvm_write_done_in(done), .nvm_write_req_out(wreq),
    .inductor_resistance_code_out(ind));
  tfn_nvm_model #(.DELAY(20)) tfn_nvm_model_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .write_req_in(wreq), .write_done_out(done));

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Strobes last one cycle; an idle cycle follows so no strobe is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge mclk_in);
    req.wr = 1'b0;
    @(negedge mclk_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge mclk_in);
    req.rd = 1'b0;
    check(rdata, e);
    @(negedge mclk_in);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  task automatic wait_burn;
    int i;
    for (i = 0; i < 200 && wreq !== 1'b0; i++) begin
      @(negedge mclk_in);
    end
    if (i == 200) begin
      errors++;
      complete_run();
    end
  endtask

  initial begin
    repeat (5) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_in = 1'b0;
    foreach (map[k]) begin
      rd(map[k], 8'h00);
    end
    idle(80);
    rd(8'h4a, 8'hc0);
    rd(8'h4b, 8'hab);
    prec = 12'h456;
    idle(80);
    rd(8'h4a, 8'h60);
    prec = 12'h789;
    idle(80);
    rd(8'h4b, 8'h45);
    idle(80);
    rd(8'h4a, 8'h90);
    rd(8'h4b, 8'h78);
    idle(4000);
    foreach (rows[k]) begin
      if (rows[k].w) begin
        wr(rows[k].a, rows[k].d);
      end else begin
        rd(rows[k].a, rows[k].e);
      end
    end
    check({4'h0, ind}, 8'h0a);
    for (int k = 0; k < 3; k++) begin
      flt = 3'b001 << k;
      idle(2);
      rd(8'h54, 8'h01 << k);
    end
    flt = '0;
    idle(2);
    rd(8'h54, 8'h00);
    // Locked area: the right pattern alone must not burn
    wr(8'h60, 8'h90);
    idle(3);
    check({7'h00, wreq}, 8'h00);
    rd(8'h60, 8'h90);
    wr(8'h61, 8'h61);
    rd(8'h61, 8'h61);
    wr(8'h60, 8'h88);
    idle(3);
    check({7'h00, wreq}, 8'h00);
    rd(8'h60, 8'h88);
    for (int k = 0; k < 2; k++) begin
      wr(8'h60, 8'h90);
      check({7'h00, wreq}, 8'h01);
      wr(8'h60, 8'h90);
      check({7'h00, wreq}, 8'h01);
      rd(8'h60, 8'h90);
      wait_burn();
      rd(8'h60, 8'h92);
    end
    wr(8'h60, 8'h00);
    rd(8'h60, 8'h02);
    // Reset in mid-burn drops the request and relocks the area
    wr(8'h60, 8'h90);
    rst_in = 1'b1;
    #1;
    check({7'h00, wreq}, 8'h00);
    check({4'h0, ind}, 8'h00);
    idle(2);
    rst_in = 1'b0;
    rd(8'h61, 8'h00);
    wr(8'h60, 8'h90);
    idle(3);
    check({7'h00, wreq}, 8'h00);
    complete_run();
  end
endmodule
